// ==== wilkinson_rundown_control.v ====
// Digital control of the 32 Wilkinson ADCs: trigger, rundown count and chip OR outputs
// What this block does
// - Discriminator firing sets a per-ADC trigger latch that shifts the threshold.
// - Discriminator release starts rundown on the next rising clock edge.
// - Rundown start closes the linear gate and turns on pedestal current.
// - Discriminator firing again ends the rundown interval.
// - A 12-bit per-ADC counter increments each clock during rundown until its overflow bit is set.
// - Full scale is 2048 counts; the 12th bit flags overflow.
// - At 40 MHz a full-scale conversion takes at most about 51 us.
// - Each result carries a fixed pedestal near 46 counts, about 1.15 us.
// - Only triggered ADCs run down; the others remain idle.
// - One output is the OR of rundown signals of powered chains.
// - Three gated ORs each combine a chosen subset of 32 rundowns.
// - Each ADC raises its loop-open flag while its feedback loop is open.
// - One output is the OR of loop-open flags of powered chains.
// - Gain-select bit picks a high/low gain ratio of 68 or 40.
// - Each of 32 ADCs has a 10-bit offset-threshold setting.
`timescale 1ns/1ps
`default_nettype none
`include "rundown_defs.vh"
module wilkinson_rundown_control #(
  parameter N = `NUM_ADCS,
  parameter W = `CNT_WIDTH
) (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Analog side, per ADC (bits 0..15 high gain, 16..31 low gain)
  input wire [N-1:0] disc_fire,
  input wire [N-1:0] loop_open_in,
  output reg [N-1:0] trigger_latch,
  output reg [N-1:0] gate_closed,
  output reg [N-1:0] pedestal_on,
  output reg [N-1:0] rundown,
  output reg [N-1:0] loop_open,
  // Configuration
  input wire [`NUM_CHAINS-1:0] chain_power,
  input wire [N*`NUM_GOR-1:0] gor_select,
  input wire gain_select,
  input wire [N*`OFFSET_WIDTH-1:0] offset_threshold,
  // Readout
  input wire [N-1:0] read_done,
  output reg [N-1:0] result_valid,
  output reg [N*W-1:0] result,
  // Chip-wide outputs and analog settings
  output reg rundown_or,
  output reg [`NUM_GOR-1:0] rundown_gor,
  output reg loop_open_or,
  output reg low_gain_double,
  output reg [N*`OFFSET_WIDTH-1:0] offset_setting
);
  // Sequencer state codes, binary encoded
  localparam [1:0] IDLE = `ST_IDLE;
  localparam [1:0] ARMED = `ST_ARMED;
  localparam [1:0] RUNNING = `ST_RUNDOWN;
  localparam [1:0] HOLDING = `ST_DONE;
  // Counter constants and group sizes
  localparam OVF = `OVF_BIT;
  localparam NG = `NUM_GOR;
  localparam [W-1:0] COUNT_ZERO = {W{1'b0}};
  localparam [W-1:0] COUNT_ONE = {{(W-1){1'b0}}, 1'b1};

  // Power mask: ADC k belongs to chain k modulo the chain count
  function [N-1:0] power_mask;
    input [`NUM_CHAINS-1:0] pw;
    integer k;
    begin
      power_mask = {N{1'b0}};
      for (k = 0; k < N; k = k + 1) begin
        power_mask[k] = pw[k % `NUM_CHAINS];
      end
    end
  endfunction

  // OR of a level set through a selection mask
  function gated_or;
    input [N-1:0] level;
    input [N-1:0] mask;
    begin
      gated_or = |(level & mask);
    end
  endfunction

  // One counter step; the count freezes once the overflow bit is set
  function [W-1:0] count_step;
    input [W-1:0] count;
    begin
      if (count[OVF]) begin
        count_step = count;
      end else begin
        count_step = count + COUNT_ONE;
      end
    end
  endfunction

  // Powered mask, sequencer state and next values
  wire [N-1:0] powered;
  reg [2*N-1:0] state;
  reg [2*N-1:0] next_state;
  reg [N-1:0] next_trigger_latch;
  reg [N-1:0] next_gate_closed;
  reg [N-1:0] next_pedestal_on;
  reg [N-1:0] next_rundown;
  reg [N-1:0] next_result_valid;
  reg [N*W-1:0] next_result;
  reg [NG-1:0] next_rundown_gor;
  integer i;
  integer g;

  // Both gains of a chain share its power bit
  assign powered = power_mask(chain_power);

  // Next values of the per-ADC conversion sequencer
  always @* begin
    next_state = state;
    next_trigger_latch = trigger_latch;
    next_gate_closed = gate_closed;
    next_pedestal_on = pedestal_on;
    next_rundown = rundown;
    next_result_valid = result_valid;
    next_result = result;
    for (i = 0; i < N; i = i + 1) begin
      case (state[2*i +: 2])
        IDLE: begin
          if (disc_fire[i] && powered[i]) begin
            next_trigger_latch[i] = 1'b1;
            next_state[2*i +: 2] = ARMED;
          end
        end
        ARMED: begin
          if (!disc_fire[i]) begin
            next_trigger_latch[i] = 1'b0;
            next_gate_closed[i] = 1'b1;
            next_pedestal_on[i] = 1'b1;
            next_rundown[i] = 1'b1;
            next_result[i*W +: W] = COUNT_ZERO;
            next_result_valid[i] = 1'b0;
            next_state[2*i +: 2] = RUNNING;
          end
        end
        RUNNING: begin
          if (disc_fire[i]) begin
            next_rundown[i] = 1'b0;
            next_pedestal_on[i] = 1'b0;
            next_result_valid[i] = 1'b1;
            next_state[2*i +: 2] = HOLDING;
          end else begin
            next_result[i*W +: W] = count_step(result[i*W +: W]);
          end
        end
        HOLDING: begin
          if (read_done[i]) begin
            next_gate_closed[i] = 1'b0;
            next_result_valid[i] = 1'b0;
            next_state[2*i +: 2] = IDLE;
          end
        end
        default: begin
          next_state[2*i +: 2] = IDLE;
        end
      endcase
    end
  end

  // Sequencer registers; results hold until read out
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= {N{IDLE}};
      trigger_latch <= {N{1'b0}};
      gate_closed <= {N{1'b0}};
      pedestal_on <= {N{1'b0}};
      rundown <= {N{1'b0}};
      result_valid <= {N{1'b0}};
      result <= {N*W{1'b0}};
    end else begin
      state <= next_state;
      trigger_latch <= next_trigger_latch;
      gate_closed <= next_gate_closed;
      pedestal_on <= next_pedestal_on;
      rundown <= next_rundown;
      result_valid <= next_result_valid;
      result <= next_result;
    end
  end

  // Gated OR selections, not gated by chain power
  always @* begin
    next_rundown_gor = {NG{1'b0}};
    for (g = 0; g < NG; g = g + 1) begin
      next_rundown_gor[g] = gated_or(rundown, gor_select[g*N +: N]);
    end
  end

  // Chip-wide ORs, loop-open flags and configuration pass-through
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rundown_or <= 1'b0;
      rundown_gor <= {NG{1'b0}};
      loop_open <= {N{1'b0}};
      loop_open_or <= 1'b0;
      low_gain_double <= 1'b0;
      offset_setting <= {N*`OFFSET_WIDTH{1'b0}};
    end else begin
      rundown_or <= gated_or(rundown, powered);
      rundown_gor <= next_rundown_gor;
      loop_open <= loop_open_in;
      loop_open_or <= gated_or(loop_open_in, powered);
      low_gain_double <= gain_select;
      offset_setting <= offset_threshold;
    end
  end
endmodule
`default_nettype wire

// ==== rundown_defs.vh ====
// Constants for the Wilkinson rundown control block
`ifndef RUNDOWN_DEFS_VH
`define RUNDOWN_DEFS_VH
`define NUM_CHAINS 16
`define NUM_ADCS 32
`define NUM_GOR 3
`define CNT_WIDTH 12
`define OVF_BIT 11
`define FULL_SCALE_COUNT 2048
`define PEDESTAL_COUNT 46
`define OFFSET_WIDTH 10
`define CLK_HZ 40000000
`define ST_IDLE 2'h0
`define ST_ARMED 2'h1
`define ST_RUNDOWN 2'h2
`define ST_DONE 2'h3
`endif

// ==== wilkinson_rundown_control_monitor.sv ====
// Rundown control port checker
`timescale 1ns/1ps
`default_nettype none
module rundown_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Per-ADC levels
  input wire logic [31:0] disc_fire,
  input wire logic [31:0] loop_open_in,
  input wire logic [31:0] trigger_latch,
  input wire logic [31:0] gate_closed,
  input wire logic [31:0] pedestal_on,
  input wire logic [31:0] rundown,
  input wire logic [31:0] result_valid,
  input wire logic [31:0] read_done,
  input wire logic [383:0] result,
  // Configuration and chip-wide outputs
  input wire logic [15:0] chain_power,
  input wire logic [95:0] gor_select,
  input wire logic rundown_or,
  input wire logic [2:0] rundown_gor,
  input wire logic loop_open_or
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Idle and armed steps of ADC 0
  sequence idle_s; !trigger_latch[0] && !gate_closed[0]; endsequence
  sequence armed_s; trigger_latch[0] && !disc_fire[0]; endsequence
  trig_set_a: assert property (idle_s ##0 disc_fire[0] && chain_power[0] |=> trigger_latch[0]) else $error("trig");
  run_start_a: assert property (armed_s |=> rundown[0] && gate_closed[0]) else $error("start");
  run_stop_a: assert property (rundown[0] && disc_fire[0] |=> !rundown[0] && result_valid[0]) else $error("stop");
  count_step_a: assert property (rundown[0] && $past(rundown[0]) && !$past(result[11])
    |-> result[11:0] == $past(result[11:0]) + 12'h001) else $error("count");
  idle_stay_a: assert property (idle_s |=> !rundown[0]) else $error("idle");
  or_out_a: assert property (rundown_or == $past(|(rundown & {chain_power, chain_power}))) else $error("or");
  hold_res_a: assert property (result_valid[0] && !read_done[0]
    |=> result_valid[0] && $stable(result[11:0])) else $error("hold");
  clr_start_a: assert property ($rose(rundown[0]) |-> result[11:0] == 12'h000) else $error("clear");
  ped_gate_a: assert property (rundown[0] |-> pedestal_on[0] && gate_closed[0]) else $error("pedestal");
  gor_out_a: assert property (rundown_gor == $past({|(rundown & gor_select[95:64]),
    |(rundown & gor_select[63:32]), |(rundown & gor_select[31:0])})) else $error("gor");
  lop_or_a: assert property (loop_open_or == $past(|(loop_open_in & {chain_power, chain_power})))
    else $error("lop");
endmodule
bind wilkinson_rundown_control rundown_monitor monitor_u (
  .core_clk(core_clk),
  .reset(reset),
  .disc_fire(disc_fire),
  .loop_open_in(loop_open_in),
  .trigger_latch(trigger_latch),
  .gate_closed(gate_closed),
  .pedestal_on(pedestal_on),
  .rundown(rundown),
  .result_valid(result_valid),
  .read_done(read_done),
  .result(result),
  .chain_power(chain_power),
  .gor_select(gor_select),
  .rundown_or(rundown_or),
  .rundown_gor(rundown_gor),
  .loop_open_or(loop_open_or)
);
`default_nettype wire

// ==== peak_model.sv ====
// Peak detector and discriminator model
`timescale 1ns/1ps
`default_nettype none
module peak_model(input wire logic core_clk, go, input wire logic [31:0] sel, input wire logic [11:0] amp,
  output logic [31:0] disc_fire, output logic [31:0] loop_open_in);
  initial {disc_fire, loop_open_in} = 64'h0;
  // Fire, release at peak, refire at baseline
  always @(posedge core_clk) if (go) begin
    @(negedge core_clk) disc_fire = sel;
    @(negedge core_clk) {disc_fire, loop_open_in} = {32'h0, sel};
    repeat (amp + 1) @(negedge core_clk);
    {disc_fire, loop_open_in} = {sel, 32'h0};
    @(negedge core_clk) disc_fire = 32'h0;
  end
endmodule
`default_nettype wire

// ==== wilkinson_rundown_control_tb_top.sv ====
// Rundown control bench
`timescale 1ns/1ps
`default_nettype none
module wilkinson_rundown_control_tb_top;
  logic core_clk = 0, reset = 1, go = 0, gain_select = 0;
  logic [31:0] sel = 0, read_done = 0;
  logic [11:0] amp = 0;
  logic [15:0] chain_power = 16'hFFFB;
  logic [95:0] gor_select = {32'h20, 32'h2_0000, 32'h1};
  logic [319:0] offset_threshold = {10{32'hA5C3_3C5A}};
  wire [31:0] disc_fire, loop_open_in, trigger_latch, gate_closed, pedestal_on, rundown, loop_open, result_valid;
  wire [383:0] result;
  wire [319:0] offset_setting;
  wire [2:0] rundown_gor;
  wire rundown_or, loop_open_or, low_gain_double;
  int fail_count = 0, check_count = 0, i;
  logic timed_out = 0;
  // Clock
  always #12.5 core_clk = ~core_clk;
  wilkinson_rundown_control dut_u (
    .core_clk(core_clk),
    .reset(reset),
    .disc_fire(disc_fire),
    .loop_open_in(loop_open_in),
    .trigger_latch(trigger_latch),
    .gate_closed(gate_closed),
    .pedestal_on(pedestal_on),
    .rundown(rundown),
    .loop_open(loop_open),
    .chain_power(chain_power),
    .gor_select(gor_select),
    .gain_select(gain_select),
    .offset_threshold(offset_threshold),
    .read_done(read_done),
    .result_valid(result_valid),
    .result(result),
    .rundown_or(rundown_or),
    .rundown_gor(rundown_gor),
    .loop_open_or(loop_open_or),
    .low_gain_double(low_gain_double),
    .offset_setting(offset_setting)
  );
  peak_model pd_u (
    .core_clk(core_clk),
    .go(go),
    .sel(sel),
    .amp(amp),
    .disc_fire(disc_fire),
    .loop_open_in(loop_open_in)
  );
  task automatic chk(input logic [383:0] seen, exp);
    check_count++;
    fail_count += (seen !== exp);
    if (seen !== exp) $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Fire ADCs, check ORs mid-rundown, then results, then read out
  task automatic run(input logic [31:0] s, input logic [11:0] a, input logic [4:0] mid, input int k);
    {sel, amp, go} = {s, a, 1'b1};
    @(negedge core_clk) go = 0;
    for (i = 0; i < 3000 && !(result_valid & s); i++) begin
      if (i == 5) begin
        chk({rundown_or, rundown_gor, loop_open_or}, mid);
        chk({pedestal_on, loop_open}, {s & {chain_power, chain_power}, s});
      end
      @(negedge core_clk);
    end
    if (i == 3000) begin
      fail_count++;
      timed_out = 1;
      return;
    end
    @(negedge core_clk);
    chk(result_valid, s & {chain_power, chain_power});
    chk({result[k*12+:12], result[11:0]}, {2{a[11] ? 12'h800 : a}});
    read_done = 32'hFFFF_FFFF;
    @(negedge core_clk) read_done = 32'h0;
    chk({result_valid, gate_closed}, 64'h0);
  endtask
  initial begin
    repeat (4) @(negedge core_clk);
    {reset, gain_select} = 2'h1;
    @(negedge core_clk) chk({low_gain_double, offset_setting}, {1'b1, offset_threshold});
    run(32'h25, 12'h02E, 5'h1B, 5);
    if (!timed_out) run(32'h2_0001, 12'h834, 5'h17, 17);
    tally_and_finish();
  end
endmodule
`default_nettype wire
